// ===== logic/uart_cs_pkg.sv
`default_nettype none
package uart_cs_pkg;
    localparam int unsigned AW = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned IDLE_W = 20;
    localparam int unsigned DEF_BIT_CYCLES = 16;

    // Register byte offsets
    localparam logic [AW-1:0] OFS_CTRL_A = 8'h00;
    localparam logic [AW-1:0] OFS_CTRL_B = 8'h04;
    localparam logic [AW-1:0] OFS_CTRL_C = 8'h08;
    localparam logic [AW-1:0] OFS_STATUS = 8'h0C;
    localparam logic [AW-1:0] OFS_DATA = 8'h10;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ctrl_reg_a fields
    localparam int unsigned A_MOD = 0;
    localparam int unsigned A_M9 = 1;
    localparam int unsigned A_WAKE = 2;
    localparam int unsigned A_PEN = 3;
    localparam int unsigned A_PODD = 4;
    localparam logic [7:0] A_MASK = 8'h1F;

    // ctrl_reg_b fields
    localparam int unsigned B_TIE = 7;
    localparam int unsigned B_TXDONE_IRQ_EN = 6;
    localparam int unsigned B_RIE = 5;
    localparam int unsigned B_IDLE_IRQ_EN = 4;
    localparam int unsigned B_TE = 3;
    localparam int unsigned B_RE = 2;
    localparam int unsigned B_RWU = 1;
    localparam int unsigned B_SBK = 0;
    localparam logic [7:0] B_ENABLES = 8'h0C;

    // ctrl_reg_c fields
    localparam int unsigned C_R8 = 7;
    localparam int unsigned C_T8 = 6;
    localparam int unsigned C_OVERRUN_IRQ_EN = 3;
    localparam int unsigned C_NOISE_IRQ_EN = 2;
    localparam int unsigned C_FRAME_IRQ_EN = 1;
    localparam int unsigned C_PARITY_IRQ_EN = 0;
    localparam logic [7:0] C_WMASK = 8'h4F;
    localparam logic [7:0] C_KEEP = 8'hC0;

    // status_reg_a fields
    localparam int unsigned S_TE = 7;
    localparam int unsigned S_TC = 6;
    localparam int unsigned S_RF = 5;
    localparam int unsigned S_ID = 4;
    localparam int unsigned S_OR = 3;
    localparam int unsigned S_NF = 2;
    localparam int unsigned S_FE = 1;
    localparam int unsigned S_PE = 0;
    localparam logic [7:0] STS_RESET = 8'hC0;
    localparam logic [7:0] RX_FLAGS = 8'h3F;

    localparam logic [3:0] FRAME_SHORT = 4'hA;
    localparam logic [3:0] FRAME_LONG = 4'hB;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_PRE = 4'h2,
        TX_BRK = 4'h4,
        TX_DATA = 4'h8
    } tx_state_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h1,
        RX_BITS = 2'h2
    } rx_state_e;

    typedef struct packed {
        logic [AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axi_rsp_s;
endpackage
`default_nettype wire

// ===== logic/async_serial_ctrl_status.sv
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_status #(
    parameter int unsigned BIT_CYCLES = uart_cs_pkg::DEF_BIT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire uart_cs_pkg::axi_req_s axi_req,
    output uart_cs_pkg::axi_rsp_s axi_rsp,
    // Serial line
    input wire logic rxd,
    output logic txd,
    // Interrupt requests
    output logic tx_irq,
    output logic rx_irq,
    output logic err_irq
);
    import uart_cs_pkg::*;

    localparam logic [CNT_W-1:0] BIT_M1 = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_HALF = CNT_W'(BIT_CYCLES / 2);
    localparam logic [IDLE_W-1:0] IDLE_SHORT = IDLE_W'(10 * BIT_CYCLES);
    localparam logic [IDLE_W-1:0] IDLE_LONG = IDLE_W'(11 * BIT_CYCLES);

    typedef struct packed {
        axi_rsp_s rsp;
        logic aw_full;
        logic w_full;
        logic [AW-1:0] waddr;
        logic [7:0] wbyte;
        logic wen;
        logic [7:0] ctl_a;
        logic [7:0] ctl_b;
        logic [7:0] ctl_c;
        logic [7:0] sts;
        logic [7:0] arm;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic pre_req;
        tx_state_e tx_st;
        logic [CNT_W-1:0] tx_cnt;
        logic [3:0] tx_bits;
        logic [10:0] tx_sh;
        logic txd;
        rx_state_e rx_st;
        logic [CNT_W-1:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [10:0] rx_sh;
        logic [2:0] rx_hist;
        logic rx_noise;
        logic [IDLE_W-1:0] idle_cnt;
        logic idle_seen;
        logic idle_arm;
        logic tx_irq;
        logic rx_irq;
        logic err_irq;
    } st_s;

    st_s st_reg;
    st_s st_next;

    // Register index 0..4, 7 when unmapped
    function automatic logic [2:0] reg_sel(input logic [AW-1:0] a);
        unique case (a)
            OFS_CTRL_A: return 3'h0;
            OFS_CTRL_B: return 3'h1;
            OFS_CTRL_C: return 3'h2;
            OFS_STATUS: return 3'h3;
            OFS_DATA: return 3'h4;
            default: return 3'h7;
        endcase
    endfunction

    // Even parity bit for odd=0, odd parity bit for odd=1
    function automatic logic par_bit(input logic [8:0] v, input logic odd);
        return (^v) ^ odd;
    endfunction

    // Data, ninth bit and buffer keep their value through reset
    function automatic st_s rst_state(input st_s s);
        st_s r;
        r = '0;
        r.sts = STS_RESET;
        r.txd = 1'b1;
        r.tx_st = TX_IDLE;
        r.rx_st = RX_IDLE;
        r.rx_hist = 3'h7;
        r.ctl_c = s.ctl_c & C_KEEP;
        r.tx_data = s.tx_data;
        r.rx_data = s.rx_data;
        return r;
    endfunction

    logic mod_on;
    logic m9;
    logic [3:0] flen;
    logic [IDLE_W-1:0] idle_len;
    logic wr;
    logic rd;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic te_rise;
    logic [7:0] bmask;
    logic b8;
    logic b7;
    logic [8:0] tdat;
    logic sample;
    logic [8:0] rdat;
    logic perr;

    always_comb begin
        st_next = st_reg;
        mod_on = st_reg.ctl_a[A_MOD];
        m9 = st_reg.ctl_a[A_M9];
        flen = m9 ? FRAME_LONG : FRAME_SHORT;
        idle_len = m9 ? IDLE_LONG : IDLE_SHORT;
        wsel = reg_sel(st_reg.waddr);
        rsel = reg_sel(axi_req.araddr);
        wr = st_reg.aw_full && st_reg.w_full && !st_reg.rsp.bvalid;
        rd = axi_req.arvalid && st_reg.rsp.arready;
        te_rise = 1'b0;
        bmask = 8'hFF;
        b8 = 1'b0;
        b7 = 1'b0;
        tdat = '0;
        sample = 1'b0;
        rdat = '0;
        perr = 1'b0;

        // Bus channels: address and data may arrive in either order
        if (axi_req.awvalid && st_reg.rsp.awready) begin
            st_next.aw_full = 1'b1;
            st_next.waddr = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_reg.rsp.wready) begin
            st_next.w_full = 1'b1;
            st_next.wbyte = axi_req.wdata[7:0];
            st_next.wen = axi_req.wstrb[0];
        end
        if (st_reg.rsp.bvalid && axi_req.bready) begin
            st_next.rsp.bvalid = 1'b0;
        end
        if (st_reg.rsp.rvalid && axi_req.rready) begin
            st_next.rsp.rvalid = 1'b0;
        end

        if (wr) begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.rsp.bvalid = 1'b1;
            st_next.rsp.bresp = (wsel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
            if (st_reg.wen) begin
                unique case (wsel)
                    3'h0: st_next.ctl_a = st_reg.wbyte & A_MASK;
                    3'h1: begin
                        // Transmit and receive enable bits are frozen while the module is off
                        if (!mod_on) begin
                            bmask = ~B_ENABLES;
                        end
                        st_next.ctl_b = (st_reg.ctl_b & ~bmask) | (st_reg.wbyte & bmask);
                        te_rise = st_next.ctl_b[B_TE] && !st_reg.ctl_b[B_TE];
                    end
                    3'h2: st_next.ctl_c = (st_reg.ctl_c & ~C_WMASK) | (st_reg.wbyte & C_WMASK);
                    3'h4: begin
                        st_next.tx_data = st_reg.wbyte;
                        if (st_reg.arm[S_TE]) begin
                            st_next.sts[S_TE] = 1'b0;
                        end
                        st_next.arm = '0;
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (rd) begin
            st_next.rsp.rvalid = 1'b1;
            st_next.rsp.rresp = (rsel == 3'h7) ? RESP_SLVERR : RESP_OKAY;
            st_next.rsp.rdata = '0;
            unique case (rsel)
                3'h0: st_next.rsp.rdata[7:0] = st_reg.ctl_a;
                3'h1: st_next.rsp.rdata[7:0] = st_reg.ctl_b;
                3'h2: st_next.rsp.rdata[7:0] = st_reg.ctl_c;
                3'h3: begin
                    st_next.rsp.rdata[7:0] = st_reg.sts;
                    st_next.arm = st_reg.sts;
                end
                3'h4: begin
                    st_next.rsp.rdata[7:0] = st_reg.rx_data;
                    st_next.sts = st_next.sts & ~(st_reg.arm & RX_FLAGS);
                    st_next.arm = '0;
                end
                default: begin
                end
            endcase
        end

        // Transmitter; engine updates after the bus so a set beats a clear
        if (!mod_on) begin
            st_next.tx_st = TX_IDLE;
            st_next.tx_cnt = '0;
            st_next.tx_bits = '0;
            st_next.txd = 1'b1;
            st_next.pre_req = 1'b0;
            st_next.sts[S_TE] = 1'b1;
        end else if (st_reg.tx_cnt != '0) begin
            st_next.tx_cnt = st_reg.tx_cnt - 1'b1;
        end else if (st_reg.tx_bits != '0) begin
            st_next.txd = st_reg.tx_sh[0];
            st_next.tx_sh = {1'b1, st_reg.tx_sh[10:1]};
            st_next.tx_bits = st_reg.tx_bits - 1'b1;
            st_next.tx_cnt = BIT_M1;
        end else begin
            // Character boundary: the current character completes first unless the module is switched off
            st_next.tx_st = TX_IDLE;
            st_next.txd = 1'b1;
            if (!st_reg.ctl_b[B_TE]) begin
                st_next.pre_req = 1'b0;
            end else if (st_reg.ctl_b[B_SBK]) begin
                // A pending preamble is dropped in favour of the break
                st_next.tx_st = TX_BRK;
                st_next.tx_sh = '0;
                st_next.tx_bits = flen;
                st_next.pre_req = 1'b0;
            end else if (st_reg.tx_st == TX_BRK) begin
                st_next.tx_st = TX_PRE;
                st_next.tx_sh = '1;
                st_next.tx_bits = 4'h1;
            end else if (st_reg.pre_req) begin
                st_next.tx_st = TX_PRE;
                st_next.tx_sh = '1;
                st_next.tx_bits = flen;
                st_next.pre_req = 1'b0;
            end else if (!st_reg.sts[S_TE]) begin
                b7 = st_reg.tx_data[7];
                b8 = st_reg.ctl_c[C_T8];
                if (st_reg.ctl_a[A_PEN]) begin
                    if (m9) begin
                        b8 = par_bit({1'b0, st_reg.tx_data}, st_reg.ctl_a[A_PODD]);
                    end else begin
                        b7 = par_bit({2'b0, st_reg.tx_data[6:0]}, st_reg.ctl_a[A_PODD]);
                    end
                end
                tdat = {b8, b7, st_reg.tx_data[6:0]};
                st_next.tx_sh = m9 ? {1'b1, tdat, 1'b0} : {2'b11, tdat[7:0], 1'b0};
                st_next.tx_bits = flen;
                st_next.tx_st = TX_DATA;
                st_next.sts[S_TE] = 1'b1;
            end
        end
        if (te_rise) begin
            st_next.pre_req = 1'b1;
        end
        st_next.sts[S_TC] = !mod_on || (st_next.sts[S_TE] && st_next.tx_bits == '0
            && st_next.tx_cnt == '0 && !st_next.pre_req
            && !(st_next.ctl_b[B_TE] && st_next.ctl_b[B_SBK]));

        // Receiver; three samples around mid-bit give the value and a noise check
        st_next.rx_hist = {st_reg.rx_hist[1:0], rxd};
        if (!mod_on || !st_reg.ctl_b[B_RE]) begin
            // Flags are left as they are
            st_next.rx_st = RX_IDLE;
            st_next.idle_cnt = '0;
            st_next.idle_seen = 1'b0;
            st_next.idle_arm = 1'b0;
        end else begin
            unique case (st_reg.rx_st)
                RX_IDLE: begin
                    if (!rxd) begin
                        st_next.rx_st = RX_BITS;
                        st_next.rx_cnt = BIT_HALF;
                        st_next.rx_bits = '0;
                        st_next.rx_noise = 1'b0;
                        st_next.idle_cnt = '0;
                        st_next.idle_seen = 1'b0;
                    end else if (st_reg.idle_cnt != idle_len) begin
                        st_next.idle_cnt = st_reg.idle_cnt + 1'b1;
                    end else if (!st_reg.idle_seen) begin
                        // One event per idle stretch
                        st_next.idle_seen = 1'b1;
                        if (st_reg.idle_arm) begin
                            st_next.sts[S_ID] = 1'b1;
                            st_next.idle_arm = 1'b0;
                        end
                        if (!st_reg.ctl_a[A_WAKE]) begin
                            st_next.ctl_b[B_RWU] = 1'b0;
                        end
                    end
                end
                RX_BITS: begin
                    if (st_reg.rx_cnt != '0) begin
                        st_next.rx_cnt = st_reg.rx_cnt - 1'b1;
                    end else begin
                        sample = (st_reg.rx_hist[0] & st_reg.rx_hist[1])
                            | (st_reg.rx_hist[1] & st_reg.rx_hist[2])
                            | (st_reg.rx_hist[0] & st_reg.rx_hist[2]);
                        st_next.rx_cnt = BIT_M1;
                        st_next.rx_noise = st_reg.rx_noise
                            | ((|st_reg.rx_hist) & ~(&st_reg.rx_hist));
                        st_next.rx_sh = {sample, st_reg.rx_sh[10:1]};
                        st_next.rx_bits = st_reg.rx_bits + 1'b1;
                        if (st_reg.rx_bits == '0 && sample) begin
                            st_next.rx_st = RX_IDLE;
                        end else if (st_next.rx_bits == flen) begin
                            st_next.rx_st = RX_IDLE;
                            // Eight-bit frames copy bit 7 into the ninth position
                            rdat = m9 ? st_next.rx_sh[9:1]
                                : {st_next.rx_sh[9], st_next.rx_sh[9:2]};
                            perr = st_reg.ctl_a[A_PEN] && (m9
                                ? par_bit(rdat, st_reg.ctl_a[A_PODD])
                                : par_bit({1'b0, rdat[7:0]}, st_reg.ctl_a[A_PODD]));
                            if (st_next.sts[S_RF]) begin
                                // Old data stays, the new character is dropped
                                st_next.sts[S_OR] = 1'b1;
                            end else begin
                                st_next.rx_data = rdat[7:0];
                                st_next.ctl_c[C_R8] = rdat[8];
                                st_next.sts[S_RF] = 1'b1;
                                st_next.sts[S_NF] = st_next.sts[S_NF] | st_next.rx_noise;
                                st_next.sts[S_FE] = st_next.sts[S_FE] | !sample;
                                st_next.sts[S_PE] = st_next.sts[S_PE] | perr;
                                st_next.idle_arm = 1'b1;
                            end
                            if (st_reg.ctl_a[A_WAKE] && (m9 ? rdat[8] : rdat[7])) begin
                                st_next.ctl_b[B_RWU] = 1'b0;
                            end
                        end
                    end
                end
            endcase
        end

        // Request lines from the updated flags
        st_next.tx_irq = mod_on && (
            (st_next.ctl_b[B_TIE] && st_next.sts[S_TE])
            || (st_next.ctl_b[B_TXDONE_IRQ_EN] && st_next.sts[S_TC]));
        st_next.rx_irq = !st_next.ctl_b[B_RWU] && (
            (st_next.ctl_b[B_RIE] && st_next.sts[S_RF])
            || (st_next.ctl_b[B_IDLE_IRQ_EN] && st_next.sts[S_ID]));
        st_next.err_irq = (st_next.ctl_c[C_OVERRUN_IRQ_EN] && st_next.sts[S_OR])
            || (st_next.ctl_c[C_NOISE_IRQ_EN] && st_next.sts[S_NF])
            || (st_next.ctl_c[C_FRAME_IRQ_EN] && st_next.sts[S_FE])
            || (st_next.ctl_c[C_PARITY_IRQ_EN] && st_next.sts[S_PE]);

        st_next.rsp.awready = !st_next.aw_full && !st_next.rsp.bvalid;
        st_next.rsp.wready = !st_next.w_full && !st_next.rsp.bvalid;
        st_next.rsp.arready = !st_next.rsp.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= rst_state(st_reg);
        end else begin
            st_reg <= st_next;
        end
    end

    assign axi_rsp = st_reg.rsp;
    assign txd = st_reg.txd;
    assign tx_irq = st_reg.tx_irq;
    assign rx_irq = st_reg.rx_irq;
    assign err_irq = st_reg.err_irq;
endmodule // async_serial_ctrl_status
`default_nettype wire

// ===== test/async_serial_ctrl_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_status_sva #(
    parameter int unsigned BIT_CYCLES = uart_cs_pkg::DEF_BIT_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire uart_cs_pkg::axi_req_s axi_req,
    input wire uart_cs_pkg::axi_rsp_s axi_rsp,
    // Serial line and requests
    input wire logic rxd,
    input wire logic txd,
    input wire logic tx_irq,
    input wire logic rx_irq,
    input wire logic err_irq
);
    import uart_cs_pkg::*;
    logic on;
    logic rd_sts;
    logic [7:0] cb;
    logic [7:0] cc;
    int unsigned low_len;
    wire wr_go = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
    wire ar_go = axi_req.arvalid && axi_rsp.arready;
    wire sts = axi_rsp.rvalid && rd_sts;
    // Shadows lead the design by one edge, so request checks allow a short lag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on <= 1'b0;
            rd_sts <= 1'b0;
            cb <= 8'h00;
            cc <= 8'h00;
            low_len <= 0;
        end else begin
            if (wr_go && axi_req.awaddr == OFS_CTRL_A) on <= axi_req.wdata[A_MOD];
            if (wr_go && axi_req.awaddr == OFS_CTRL_B) cb <= axi_req.wdata[7:0];
            if (wr_go && axi_req.awaddr == OFS_CTRL_C) cc <= axi_req.wdata[7:0];
            if (ar_go) rd_sts <= axi_req.araddr == OFS_STATUS;
            low_len <= txd ? 0 : low_len + 1;
        end
    end
    a_reset_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> txd && !tx_irq && !rx_irq && !err_irq) else $error("outputs busy after reset");
    a_whole_bits: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(txd) |-> low_len % BIT_CYCLES == 0) else $error("txd low run not whole bits");
    a_write_ans: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid) else $error("write answer late");
    a_read_ans: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_go |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h0
        && (axi_rsp.rresp == RESP_SLVERR) == ($past(axi_req.araddr) > OFS_DATA
        || $past(axi_req.araddr[1:0]) != 2'h0)) else $error("read answer wrong");
    a_tx_req: assert property (@(posedge aclk) disable iff (!aresetn)
        sts && on && cb[B_TIE] && axi_rsp.rdata[S_TE] |-> ##[0:2] tx_irq) else $error("tx request missing");
    a_rx_req: assert property (@(posedge aclk) disable iff (!aresetn)
        sts && !cb[B_RWU] && cb[B_RIE] && axi_rsp.rdata[S_RF] |-> ##[0:2] rx_irq) else $error("rx request missing");
    a_err_req: assert property (@(posedge aclk) disable iff (!aresetn)
        sts && |(axi_rsp.rdata[3:0] & cc[3:0]) |-> ##[0:2] err_irq) else $error("error request missing");
    a_err_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        err_irq |-> |cc[3:0] || |($past(cc, 3) & 8'h0F)) else $error("error request unmasked");
endmodule // async_serial_ctrl_status_sva
bind async_serial_ctrl_status async_serial_ctrl_status_sva #(.BIT_CYCLES(BIT_CYCLES)) i_async_serial_ctrl_status_sva (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp), .rxd(rxd), .txd(txd),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
`default_nettype wire

// ===== test/serial_peer.sv
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int unsigned BIT = 4
) (
    // Line
    input wire logic aclk,
    output logic rxd,
    input wire logic txd
);
    // Line rests high between frames, as its pull-up leaves it
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] v, input logic stop);
        logic [9:0] f;
        f = {stop, v, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT) @(posedge aclk);
        end
        rxd <= 1'b1;
        @(posedge aclk);
    endtask
    // Samples mid-bit; a stop bit seen low reports failure
    task automatic recv(output logic [7:0] v, output logic ok);
        int n;
        for (n = 0; n < 400 && txd; n++)
            @(posedge aclk);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge aclk);
            v[i] = txd;
        end
        repeat (BIT) @(posedge aclk);
        ok = (n < 400) && txd;
    endtask
endmodule // serial_peer
`default_nettype wire

// ===== test/async_serial_ctrl_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_ctrl_status_test;
    import uart_cs_pkg::*;
    localparam int unsigned BIT = 4;
    logic aclk;
    logic aresetn;
    axi_req_s req;
    axi_rsp_s rsp;
    logic rxd;
    logic txd;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
    logic [7:0] d;
    logic [1:0] r;
    logic ok;
    int n_mismatch;
    int check_count;
    async_serial_ctrl_status #(.BIT_CYCLES(BIT)) i_async_serial_ctrl_status (.aclk(aclk), .aresetn(aresetn),
        .axi_req(req), .axi_rsp(rsp), .rxd(rxd), .txd(txd), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
    serial_peer #(.BIT(BIT)) i_serial_peer (.aclk(aclk), .rxd(rxd), .txd(txd));
    always #2.5 aclk = ~aclk;
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Address and data go up together; each is dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        int n;
        req.awaddr <= a;
        req.wdata <= {24'h0, v};
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        if (n == 40) n_mismatch++;
        if (n == 40) results();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [1:0] rs);
        int n;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        v = rsp.rdata[7:0];
        rs = rsp.rresp;
        if (n == 40) n_mismatch++;
        if (n == 40) results();
    endtask
    task automatic s_reset();
        rd(OFS_STATUS, d, r);
        chk("status", d, STS_RESET);
        rd(OFS_CTRL_B, d, r);
        chk("ctrl_b", d, 8'h00);
        rd(OFS_CTRL_C, d, r);
        chk("ctrl_c", d & 8'h07, 8'h00);
        wr(OFS_CTRL_C, 8'h0F);
        rd(OFS_CTRL_C, d, r);
        chk("ctrl_c", d & 8'h4F, 8'h0F);
        rd(8'h40, d, r);
        chk("unmapped", {6'h0, r}, {6'h0, RESP_SLVERR});
    endtask
    task automatic s_rx();
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_CTRL_B, 8'h24);
        i_serial_peer.send(8'h3C, 1'b1);
        chk("rx_irq", {7'h0, rx_irq}, 8'h01);
        rd(OFS_STATUS, d, r);
        chk("rx flags", d & 8'h2F, 8'h20);
        rd(OFS_DATA, d, r);
        chk("rx data", d, 8'h3C);
        rd(OFS_STATUS, d, r);
        chk("rx flags", d & 8'h2F, 8'h00);
        i_serial_peer.send(8'hA5, 1'b1);
        i_serial_peer.send(8'h22, 1'b1);
        rd(OFS_STATUS, d, r);
        chk("overrun", d & 8'h28, 8'h28);
        rd(OFS_CTRL_C, d, r);
        chk("ninth bit", d & 8'h80, 8'h80);
        rd(OFS_DATA, d, r);
        chk("kept data", d, 8'hA5);
    endtask
    task automatic s_err();
        i_serial_peer.send(8'h55, 1'b0);
        chk("err_irq", {7'h0, err_irq}, 8'h01);
        rd(OFS_STATUS, d, r);
        chk("framing", d & 8'h0B, 8'h02);
        rd(OFS_DATA, d, r);
        rd(OFS_STATUS, d, r);
        chk("framing", d & 8'h0B, 8'h00);
        chk("err_irq", {7'h0, err_irq}, 8'h00);
    endtask
    task automatic s_tx();
        wr(OFS_CTRL_B, 8'h88);
        rd(OFS_STATUS, d, r);
        chk("tx flags", d & 8'hC0, 8'h80);
        chk("tx_irq", {7'h0, tx_irq}, 8'h01);
        wr(OFS_DATA, 8'hA5);
        i_serial_peer.recv(d, ok);
        chk("tx data", d, 8'hA5);
        chk("tx stop", {7'h0, ok}, 8'h01);
        repeat (4 * BIT) @(posedge aclk);
        rd(OFS_STATUS, d, r);
        chk("tx flags", d & 8'hC0, 8'hC0);
        wr(OFS_CTRL_A, 8'h00);
        rd(OFS_STATUS, d, r);
        chk("tx flags", d & 8'hC0, 8'hC0);
        chk("tx_irq", {7'h0, tx_irq}, 8'h00);
    endtask
    task automatic s_brk();
        int n;
        wr(OFS_CTRL_A, 8'h01);
        wr(OFS_CTRL_B, 8'h5C);
        chk("tx_irq", {7'h0, tx_irq}, 8'h01);
        i_serial_peer.send(8'h81, 1'b1);
        chk("rx_irq", {7'h0, rx_irq}, 8'h00);
        repeat (11 * BIT) @(posedge aclk);
        chk("rx_irq", {7'h0, rx_irq}, 8'h01);
        // Break is raised long after transmit-empty last set
        wr(OFS_CTRL_B, 8'h5D);
        for (n = 0; n < 40 && txd; n++)
            @(posedge aclk);
        repeat (8 * BIT) @(posedge aclk);
        chk("break", {6'h0, txd, tx_irq}, 8'h00);
        wr(OFS_CTRL_B, 8'h5C);
        repeat (3 * BIT) @(posedge aclk);
        chk("break end", {6'h0, txd, tx_irq}, 8'h03);
        wr(OFS_CTRL_B, 8'h58);
        rd(OFS_STATUS, d, r);
        chk("rx flags", d & 8'h30, 8'h30);
    endtask
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        req = '0;
        req.wstrb = 4'hF;
        req.bready = 1'b1;
        req.rready = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        s_reset();
        s_rx();
        s_err();
        s_tx();
        s_brk();
        results();
    end
endmodule // async_serial_ctrl_status_test
`default_nettype wire
